// ---- verilog/pcs_cfg.svh ----
// Constants of the PCM codec serial port: offsets, fields, timing.
// Included by the package and by each module of the block.
`ifndef PCS_CFG_SVH
`define PCS_CFG_SVH
`define PCS_SYS_CLK_HZ 20000000
`define PCS_WORD_BITS 8
`define PCS_RANGE_BITS 12
`define PCS_RX_STBY_MS 30
`define PCS_TX_STBY_MS 300
`define PCS_RX_STBY_CYC (`PCS_RX_STBY_MS * (`PCS_SYS_CLK_HZ / 1000))
`define PCS_TX_STBY_CYC (`PCS_TX_STBY_MS * (`PCS_SYS_CLK_HZ / 1000))
`define PCS_STBY_CNT_W 23
`define PCS_BCLK_MIN_HZ 64000
`define PCS_BCLK_MAX_HZ 2048000
`define PCS_MCLK_A_HZ 2048000
`define PCS_MCLK_B_HZ 1536000
`define PCS_MODE_WIN_CYC (2 * `PCS_SYS_CLK_HZ / `PCS_BCLK_MIN_HZ)
`define PCS_MODE_CNT_W 10
`define PCS_ADDR_W 4
`define PCS_TXDATA_OFS 4'h0
`define PCS_RXDATA_OFS 4'h4
`define PCS_STATUS_OFS 4'h8
`define PCS_RXD_NEW_BIT 8
`define PCS_ST_FIXED_BIT 0
`define PCS_ST_RX_STBY_BIT 1
`define PCS_ST_TX_STBY_BIT 2
`define PCS_ST_ACTIVE_BIT 3
`define PCS_TXDATA_RST 8'hFF
`endif

// ---- verilog/pcs_pkg.sv ----
// Types shared by the PCM codec serial port modules.
// Widths come from pcs_cfg.svh.
`include "pcs_cfg.svh"
package pcs_pkg;
  typedef logic [`PCS_WORD_BITS-1:0] pcs_word_type;
  typedef logic [`PCS_STBY_CNT_W-1:0] pcs_stby_cnt_type;
  typedef logic [`PCS_MODE_CNT_W-1:0] pcs_mode_cnt_type;
  typedef enum logic {PCS_MODE_FIXED, PCS_MODE_VARIABLE} pcs_mode_type;
endpackage

// ---- verilog/pcs_lane.sv ----
// One direction of the PCM word link, running on its own bit clock.
// Assumes frame sync / slot enable and serial data are timed by that clock.
`timescale 1ns/100ps
`include "pcs_cfg.svh"
module pcs_lane
  import pcs_pkg::*;
#(
  parameter bit RX = 1'b0
)
(
  input wire logic bclk_i,
  input wire logic rst_i,
  input wire logic frame_i,
  input wire logic ser_i,
  input wire logic en_i,
  input wire logic fixed_i,
  input wire pcs_word_type word_i,
  input wire logic req_tgl_i,
  output logic ack_tgl_o,
  output pcs_word_type word_o,
  output logic done_tgl_o,
  output logic ser_o,
  output logic ser_oe_n_o,
  output logic strobe_oe_n_o
);
  localparam logic [3:0] LAST = RX ? 4'(`PCS_WORD_BITS - 1) : 4'(`PCS_WORD_BITS);
  logic lclk;
  logic rs1_reg;
  logic lrst;
  logic [2:0] sync1_reg;
  logic [2:0] sync2_reg;
  logic len;
  logic lfix;
  logic [3:0] cnt_reg;
  logic armed_reg;
  logic go;
  logic abort;
  pcs_word_type sh_reg;
  pcs_word_type word_reg;

  // Receive samples on falling edges, so it runs on the inverted clock
  assign lclk = RX ? ~bclk_i : bclk_i;

  // Reset asserts at once, releases after two link edges
  always_ff @(posedge lclk or posedge rst_i)
  begin
    if (rst_i)
    begin
      rs1_reg <= 1'b1;
      lrst <= 1'b1;
    end
    else
    begin
      rs1_reg <= 1'b0;
      lrst <= rs1_reg;
    end
  end

  // Enable, mode and request toggle from the system clock
  always_ff @(posedge lclk)
  begin
    sync1_reg <= {en_i, fixed_i, req_tgl_i};
    sync2_reg <= sync1_reg;
  end
  assign len = sync2_reg[2];
  assign lfix = sync2_reg[1];

  // A word starts on the first edge that sees the frame high
  assign go = len && armed_reg && frame_i && cnt_reg == 4'h0;
  // A slot enable that drops early ends the word
  assign abort = !lfix && !frame_i && cnt_reg != 4'h0;

  // Bit counter and arming: one word per frame sync or slot
  always_ff @(posedge lclk or posedge lrst)
  begin
    if (lrst)
    begin
      cnt_reg <= 4'h0;
      armed_reg <= 1'b0;
    end
    else
    begin
      if (!frame_i)
        armed_reg <= 1'b1;
      else if (go)
        armed_reg <= 1'b0;
      if (!len || abort || cnt_reg == LAST)
        cnt_reg <= 4'h0;
      else if (go || cnt_reg != 4'h0)
        cnt_reg <= cnt_reg + 4'h1;
    end
  end

  // Shift register, sign bit first in both directions
  always_ff @(posedge lclk or posedge lrst)
  begin
    if (lrst)
      sh_reg <= 8'h00;
    else if (RX && (go || cnt_reg != 4'h0))
      sh_reg <= {sh_reg[6:0], ser_i};
    else if (!RX && go)
      sh_reg <= {word_reg[6:0], 1'b0};
    else if (!RX && cnt_reg != 4'h0)
      sh_reg <= {sh_reg[6:0], 1'b0};
  end

  // Transmit pin drive and the open-drain slot strobe
  always_ff @(posedge lclk or posedge lrst)
  begin
    if (lrst)
    begin
      ser_o <= 1'b0;
      ser_oe_n_o <= 1'b1;
      strobe_oe_n_o <= 1'b1;
    end
    else if (RX || !len || abort || cnt_reg == LAST)
    begin
      ser_o <= 1'b0;
      ser_oe_n_o <= 1'b1;
      strobe_oe_n_o <= 1'b1;
    end
    else if (go)
    begin
      ser_o <= word_reg[7];
      ser_oe_n_o <= 1'b0;
      strobe_oe_n_o <= !lfix;
    end
    else if (cnt_reg != 4'h0)
      ser_o <= sh_reg[7];
  end

  // Finished receive word and its toggle toward the system clock
  always_ff @(posedge lclk or posedge lrst)
  begin
    if (lrst)
    begin
      word_o <= 8'h00;
      done_tgl_o <= 1'b0;
    end
    else if (RX && len && !abort && cnt_reg == LAST)
    begin
      word_o <= {sh_reg[6:0], ser_i};
      done_tgl_o <= ~done_tgl_o;
    end
  end

  // New transmit word: held stable by the sender until acknowledged
  always_ff @(posedge lclk or posedge lrst)
  begin
    if (lrst)
    begin
      word_reg <= `PCS_TXDATA_RST;
      ack_tgl_o <= 1'b0;
    end
    else if (sync2_reg[0] != ack_tgl_o)
    begin
      word_reg <= word_i;
      ack_tgl_o <= sync2_reg[0];
    end
  end

  default clocking lcb @(posedge lclk);
  endclocking
  default disable iff (lrst);

  property p_tx_eight;
    disable iff (lrst || !len) !RX && go && lfix |=> !ser_oe_n_o [*8] ##1 ser_oe_n_o;
  endproperty
  a_tx_eight: assert property (p_tx_eight) else $error("tx word not eight edges");
  property p_tx_msb;
    !RX && go |=> ser_o == $past(word_reg[7]);
  endproperty
  a_tx_msb: assert property (p_tx_msb) else $error("tx sign bit not first");
  property p_rx_eight;
    disable iff (lrst || !len) RX && go && lfix |-> ##8 $changed(done_tgl_o);
  endproperty
  a_rx_eight: assert property (p_rx_eight) else $error("rx word not eight edges");
  property p_strobe_fix;
    !RX && $fell(ser_oe_n_o) && $past(lfix) |-> !strobe_oe_n_o;
  endproperty
  a_strobe_fix: assert property (p_strobe_fix) else $error("no slot strobe");
  property p_strobe_var;
    !RX && $fell(ser_oe_n_o) && !$past(lfix) |-> strobe_oe_n_o;
  endproperty
  a_strobe_var: assert property (p_strobe_var) else $error("strobe in variable mode");
  c_word: cover property ($changed(done_tgl_o));
endmodule

// ---- verilog/pcs_serial_port.sv ----
// Serial port and channel control of a single-channel mu-law voice codec.
// Assumes a DSP serial port on the link and an Avalon-MM master for registers.
// How it works
// - Receive mode-select pin held still (tied off) selects fixed rate for both channels.
// - Edges on that pin select variable rate; it then clocks receive, 64 kHz-2.048 MHz.
// - Fixed rate: master clock is the bit clock; variable rate: filters only.
// - Receive channel enters standby after its frame sync stays low 30 ms.
// - Transmit channel enters standby after its frame sync stays low 300 ms.
// - Transmit frame sync governs transmit alone, like receive frame sync does receive.
// - Receive word is sampled on eight consecutive falling edges of its bit clock.
// - Transmit word is shifted out on eight consecutive rising edges of its bit clock.
// - Power-down input low makes the device inactive; high makes it active.
// - Fixed rate: shared transmit pin is an open-drain strobe while data is driven.
// - Variable rate: shared transmit pin is an input carrying the transmit bit clock.
// - Each sample is one 8-bit mu-law code word covering 12 bits of range.
`timescale 1ns/100ps
`include "pcs_cfg.svh"
module pcs_serial_port
  import pcs_pkg::*;
#(
  parameter int RX_STANDBY_CYC = `PCS_RX_STBY_CYC,
  parameter int TX_STANDBY_CYC = `PCS_TX_STBY_CYC
)
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic mclk_i,
  input wire logic rx_bit_clock_mode_sel_i,
  input wire logic rx_frame_sync_slot_en_i,
  input wire logic tx_frame_sync_slot_en_i,
  input wire logic pcm_in_i,
  output logic pcm_out_o,
  output logic pcm_out_oe_n_o,
  input wire logic power_down_n_i,
  input wire logic tx_strobe_or_bit_clock_i,
  output logic tx_strobe_or_bit_clock_o,
  output logic tx_strobe_or_bit_clock_oe_n_o,
  input wire logic [`PCS_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [3:0] avs_byteenable_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o
);
  logic [5:0] s1_reg;
  logic [5:0] s2_reg;
  logic [1:0] s3_reg;
  logic dclk_s2;
  logic rx_fs_s2;
  logic tx_fs_s2;
  logic pdn_s2;
  logic ack_s2;
  logic dclk_edge;
  logic done_edge;
  pcs_mode_type mode_reg;
  pcs_mode_cnt_type mode_cnt_reg;
  pcs_mode_cnt_type mode_win;
  logic fixed;
  logic pwr_reg;
  pcs_stby_cnt_type rx_low_cnt_reg;
  pcs_stby_cnt_type rx_low_cnt_next;
  pcs_stby_cnt_type tx_low_cnt_reg;
  pcs_stby_cnt_type tx_low_cnt_next;
  pcs_stby_cnt_type rx_lim;
  pcs_stby_cnt_type tx_lim;
  logic rx_standby_reg;
  logic tx_standby_reg;
  pcs_word_type tx_hold_reg;
  logic tx_req_reg;
  logic tx_busy;
  pcs_word_type rx_word_reg;
  logic rx_new_reg;
  logic rx_done_tgl;
  logic tx_ack_tgl;
  pcs_word_type rx_lane_word;
  logic accept;
  logic wr_tx;
  logic rd_rx;
  logic [31:0] status_word;
  logic [31:0] rxdata_word;
  logic rx_bclk;
  logic tx_bclk;

  // Saturating count of cycles a frame input has been low
  function automatic pcs_stby_cnt_type low_count(input pcs_stby_cnt_type cnt,
                                                 input logic low,
                                                 input pcs_stby_cnt_type lim);
    if (!low)
      low_count = '0;
    else if (cnt == lim)
      low_count = cnt;
    else
      low_count = cnt + 1'b1;
  endfunction

  // True when the bus address selects the given register
  function automatic logic hit(input logic [`PCS_ADDR_W-1:0] addr,
                               input logic [`PCS_ADDR_W-1:0] ofs);
    hit = addr == ofs;
  endfunction

  // Mode, frame and power-down pins and link toggles pass two flops before any system-clock logic
  always_ff @(posedge sys_clk_i)
  begin
    s1_reg <= {rx_bit_clock_mode_sel_i, rx_frame_sync_slot_en_i,
               tx_frame_sync_slot_en_i, power_down_n_i, rx_done_tgl, tx_ack_tgl};
    s2_reg <= s1_reg;
  end

  // Third stage only for edge detection on the clock pin and rx toggle
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      s3_reg <= 2'h0;
    else
      s3_reg <= {s2_reg[5], s2_reg[1]};
  end

  assign dclk_s2 = s2_reg[5];
  assign rx_fs_s2 = s2_reg[4];
  assign tx_fs_s2 = s2_reg[3];
  assign pdn_s2 = s2_reg[2];
  assign ack_s2 = s2_reg[0];
  assign dclk_edge = dclk_s2 ^ s3_reg[1];
  assign done_edge = s2_reg[1] ^ s3_reg[0];

  // Rate mode: a still pin for two slowest bit periods means fixed rate
  assign mode_win = pcs_mode_cnt_type'(`PCS_MODE_WIN_CYC);
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      mode_reg <= PCS_MODE_FIXED;
      mode_cnt_reg <= '0;
    end
    else if (dclk_edge)
    begin
      mode_reg <= PCS_MODE_VARIABLE;
      mode_cnt_reg <= '0;
    end
    else if (mode_cnt_reg == mode_win)
      mode_reg <= PCS_MODE_FIXED;
    else
      mode_cnt_reg <= mode_cnt_reg + 1'b1;
  end
  assign fixed = mode_reg == PCS_MODE_FIXED;

  // Bit clocks per mode; the mode is a board strap, so the mux never
  // switches in service and its glitch on a change is accepted
  assign rx_bclk = fixed ? mclk_i : rx_bit_clock_mode_sel_i;
  assign tx_bclk = fixed ? mclk_i : tx_strobe_or_bit_clock_i;

  // Power-down input gates both lanes
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      pwr_reg <= 1'b0;
    else
      pwr_reg <= pdn_s2;
  end

  // Standby timers, one per channel, each on its own frame input
  assign rx_lim = pcs_stby_cnt_type'(RX_STANDBY_CYC);
  assign tx_lim = pcs_stby_cnt_type'(TX_STANDBY_CYC);
  assign rx_low_cnt_next = low_count(rx_low_cnt_reg, !rx_fs_s2, rx_lim);
  assign tx_low_cnt_next = low_count(tx_low_cnt_reg, !tx_fs_s2, tx_lim);

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      rx_low_cnt_reg <= '0;
      rx_standby_reg <= 1'b0;
    end
    else
    begin
      rx_low_cnt_reg <= rx_low_cnt_next;
      rx_standby_reg <= rx_low_cnt_next == rx_lim;
    end
  end

  // Independent of the receive timer on purpose
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      tx_low_cnt_reg <= '0;
      tx_standby_reg <= 1'b0;
    end
    else
    begin
      tx_low_cnt_reg <= tx_low_cnt_next;
      tx_standby_reg <= tx_low_cnt_next == tx_lim;
    end
  end

  // Bus accept: a transmit word write waits while the last one crosses
  assign tx_busy = tx_req_reg != ack_s2;
  assign wr_tx = avs_write_i && hit(avs_address_i, `PCS_TXDATA_OFS);
  assign rd_rx = avs_read_i && hit(avs_address_i, `PCS_RXDATA_OFS);
  assign accept = (avs_read_i || avs_write_i) && avs_waitrequest_o && !(wr_tx && tx_busy);

  // Waitrequest drops for exactly one cycle per accepted request
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      avs_waitrequest_o <= 1'b1;
    else
      avs_waitrequest_o <= !accept;
  end

  // Transmit word register and its toggle request to the tx lane
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      tx_hold_reg <= `PCS_TXDATA_RST;
      tx_req_reg <= 1'b0;
    end
    else if (accept && wr_tx && avs_byteenable_i[0])
    begin
      tx_hold_reg <= avs_writedata_i[7:0];
      tx_req_reg <= ~tx_req_reg;
    end
  end

  // Received word; the new flag is set by the link, cleared by a read
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      rx_word_reg <= 8'h00;
      rx_new_reg <= 1'b0;
    end
    else if (done_edge)
    begin
      rx_word_reg <= rx_lane_word;
      rx_new_reg <= 1'b1;
    end
    else if (accept && rd_rx)
      rx_new_reg <= 1'b0;
  end

  // Read words with unused bits at zero
  always_comb
  begin
    status_word = 32'h00000000;
    status_word[`PCS_ST_FIXED_BIT] = fixed;
    status_word[`PCS_ST_RX_STBY_BIT] = rx_standby_reg;
    status_word[`PCS_ST_TX_STBY_BIT] = tx_standby_reg;
    status_word[`PCS_ST_ACTIVE_BIT] = pwr_reg;
    rxdata_word = 32'h00000000;
    rxdata_word[`PCS_WORD_BITS-1:0] = rx_word_reg;
    rxdata_word[`PCS_RXD_NEW_BIT] = rx_new_reg;
  end

  // Read data is loaded as the request is accepted; unmapped reads zero
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      avs_readdata_o <= 32'h00000000;
    else if (accept && avs_read_i)
    begin
      case (avs_address_i)
        `PCS_TXDATA_OFS: avs_readdata_o <= {24'h000000, tx_hold_reg};
        `PCS_RXDATA_OFS: avs_readdata_o <= rxdata_word;
        `PCS_STATUS_OFS: avs_readdata_o <= status_word;
        default: avs_readdata_o <= 32'h00000000;
      endcase
    end
  end

  // Open drain: the pin is only ever pulled low
  assign tx_strobe_or_bit_clock_o = 1'b0;

  // Receive lane on falling edges of its bit clock
  pcs_lane #(
    .RX(1'b1)
  ) u_rx (
    .bclk_i(rx_bclk),
    .rst_i(rst_i),
    .frame_i(rx_frame_sync_slot_en_i),
    .ser_i(pcm_in_i),
    .en_i(pwr_reg),
    .fixed_i(fixed),
    .word_i(tx_hold_reg),
    .req_tgl_i(1'b0),
    .ack_tgl_o(),
    .word_o(rx_lane_word),
    .done_tgl_o(rx_done_tgl),
    .ser_o(),
    .ser_oe_n_o(),
    .strobe_oe_n_o()
  );

  // Transmit lane on rising edges, driving data and strobe
  pcs_lane #(
    .RX(1'b0)
  ) u_tx (
    .bclk_i(tx_bclk),
    .rst_i(rst_i),
    .frame_i(tx_frame_sync_slot_en_i),
    .ser_i(1'b0),
    .en_i(pwr_reg),
    .fixed_i(fixed),
    .word_i(tx_hold_reg),
    .req_tgl_i(tx_req_reg),
    .ack_tgl_o(tx_ack_tgl),
    .word_o(),
    .done_tgl_o(),
    .ser_o(pcm_out_o),
    .ser_oe_n_o(pcm_out_oe_n_o),
    .strobe_oe_n_o(tx_strobe_or_bit_clock_oe_n_o)
  );

  default clocking scb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  property p_rx_stby;
    $rose(rx_standby_reg) |-> rx_low_cnt_reg == rx_lim && !$past(rx_fs_s2);
  endproperty
  a_rx_stby: assert property (p_rx_stby) else $error("rx standby early");
  property p_rx_wake;
    rx_fs_s2 |=> !rx_standby_reg && rx_low_cnt_reg == '0;
  endproperty
  a_rx_wake: assert property (p_rx_wake) else $error("rx standby kept");
  property p_tx_stby;
    $rose(tx_standby_reg) |-> tx_low_cnt_reg == tx_lim && !$past(tx_fs_s2);
  endproperty
  a_tx_stby: assert property (p_tx_stby) else $error("tx standby early");
  property p_tx_wake;
    tx_fs_s2 && !rx_fs_s2 |=> !tx_standby_reg && tx_low_cnt_reg == '0;
  endproperty
  a_tx_wake: assert property (p_tx_wake) else $error("tx standby not own");
  property p_mode_var;
    dclk_edge |=> mode_reg == PCS_MODE_VARIABLE ##1 !fixed || dclk_edge || $past(dclk_edge);
  endproperty
  a_mode_var: assert property (p_mode_var) else $error("no variable mode");
  property p_mode_fix;
    mode_cnt_reg == mode_win && !dclk_edge |=> fixed;
  endproperty
  a_mode_fix: assert property (p_mode_fix) else $error("no fixed mode");
  property p_pdn;
    $fell(pdn_s2) |=> !pwr_reg ##1 !status_word[`PCS_ST_ACTIVE_BIT] || pdn_s2;
  endproperty
  a_pdn: assert property (p_pdn) else $error("power-down ignored");
  property p_rx_word;
    done_edge |=> rx_new_reg && rx_word_reg == $past(rx_lane_word);
  endproperty
  a_rx_word: assert property (p_rx_word) else $error("rx word lost");
  c_rx_stby: cover property ($rose(rx_standby_reg));
  c_var_rx: cover property (!fixed && done_edge);
  c_tx_wr: cover property (accept && wr_tx);
endmodule

// ---- testbench/pcs_dsp_model.sv ----
// Behavioural model of the signal processor serial port facing the codec port.
// Assumes the bench resolves the shared transmit pin and feeds the mode pin.
`timescale 1ns/100ps
module pcs_dsp_model
  import pcs_pkg::*;
#(
  parameter realtime HALF = 6.0
)
(
  input wire logic var_mode_i,
  input wire logic pcm_i,
  input wire logic pcm_oe_n_i,
  input wire logic strobe_oe_n_i,
  output logic mclk_o,
  output logic dclk_o,
  output logic rx_frame_o,
  output logic tx_frame_o,
  output logic pcm_o
);
  logic bclk;
  // Set by the bench to run a slot on the transmit side only
  logic rx_skip = 1'b0;

  // Master clock runs free, it also feeds the filters
  initial
  begin
    mclk_o = 1'b0;
    forever #(HALF) mclk_o = ~mclk_o;
  end

  // Data clock offset 2.3 ns with the same period, so it keeps a fixed phase to the master clock
  initial
  begin
    dclk_o = 1'b0;
    #2.3;
    forever #(HALF) dclk_o = ~dclk_o;
  end

  initial
  begin
    rx_frame_o = 1'b0;
    tx_frame_o = 1'b0;
    pcm_o = 1'b0;
  end

  // Bit clock only switched while no frame is open
  assign bclk = var_mode_i ? dclk_o : mclk_o;

  // One slot in both directions; ok drops if drive or strobe misbehave
  task automatic xfer(input pcs_word_type rx_w, output pcs_word_type tx_w, output logic ok);
    int i;
    ok = 1'b1;
    @(posedge bclk);
    rx_frame_o <= !rx_skip;
    tx_frame_o <= 1'b1;
    pcm_o <= rx_w[7];
    for (i = 0; i < 8; i++)
    begin
      @(posedge bclk);
      if (i < 7)
        pcm_o <= rx_w[6-i];
      else
      begin
        pcm_o <= ~rx_w[0]; // Released line shows no stale bit
        rx_frame_o <= 1'b0;
        tx_frame_o <= 1'b0;
      end
      @(negedge bclk);
      tx_w[7-i] = pcm_i;
      if (pcm_oe_n_i !== 1'b0 || strobe_oe_n_i !== var_mode_i)
        ok = 1'b0;
    end
  endtask
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for the codec serial port: bus tasks plus link model.
// Assumes standby counts shortened through the top module parameters.
`timescale 1ns/100ps
`include "pcs_cfg.svh"
module testbench
  import pcs_pkg::*;
;
  localparam logic [31:0] ST_FIX = 32'h1 << `PCS_ST_FIXED_BIT;
  localparam logic [31:0] ST_RXS = 32'h1 << `PCS_ST_RX_STBY_BIT;
  localparam logic [31:0] ST_TXS = 32'h1 << `PCS_ST_TX_STBY_BIT;
  localparam logic [31:0] ST_ACT = 32'h1 << `PCS_ST_ACTIVE_BIT;
  localparam logic [31:0] NEW = 32'h1 << `PCS_RXD_NEW_BIT;
  logic sys_clk_i, rst_i, power_down_n_i, var_mode, mclk, dclk, mode_pin, rx_frame, tx_frame;
  logic pcm_in, pcm_out, pcm_out_oe_n, tx_pin_o, tx_pin_oe_n, tx_pin, avs_read, avs_write;
  logic avs_waitrequest, ok;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, q;
  pcs_word_type txw;
  pcs_word_type tx_tab [4] = '{8'h80, 8'h01, 8'h3C, 8'h00};
  pcs_word_type rx_tab [4] = '{8'h01, 8'h80, 8'hC3, 8'hFF};
  int failures, checks_done, k;

  // Mode pin reads low when tied off, else it carries the receive clock
  assign mode_pin = var_mode ? dclk : 1'b0;
  // Open-drain strobe with pull-up; in variable rate the processor clocks it
  assign tx_pin = !tx_pin_oe_n ? tx_pin_o : (var_mode ? dclk : 1'b1);

  pcs_serial_port #(.RX_STANDBY_CYC(200), .TX_STANDBY_CYC(400)) pcs_serial_port_inst (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .mclk_i(mclk), .rx_bit_clock_mode_sel_i(mode_pin),
    .rx_frame_sync_slot_en_i(rx_frame), .tx_frame_sync_slot_en_i(tx_frame),
    .pcm_in_i(pcm_in), .pcm_out_o(pcm_out), .pcm_out_oe_n_o(pcm_out_oe_n),
    .power_down_n_i(power_down_n_i), .tx_strobe_or_bit_clock_i(tx_pin),
    .tx_strobe_or_bit_clock_o(tx_pin_o), .tx_strobe_or_bit_clock_oe_n_o(tx_pin_oe_n),
    .avs_address_i(avs_address), .avs_read_i(avs_read), .avs_write_i(avs_write),
    .avs_byteenable_i(avs_byteenable), .avs_writedata_i(avs_writedata),
    .avs_readdata_o(avs_readdata), .avs_waitrequest_o(avs_waitrequest));

  pcs_dsp_model pcs_dsp_model_inst (
    .var_mode_i(var_mode), .pcm_i(pcm_out), .pcm_oe_n_i(pcm_out_oe_n),
    .strobe_oe_n_i(tx_pin_oe_n), .mclk_o(mclk), .dclk_o(dclk), .rx_frame_o(rx_frame),
    .tx_frame_o(tx_frame), .pcm_o(pcm_in));

  initial
  begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      failures++;
    end
  endtask

  // One bus cycle; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do
    begin
      @(posedge sys_clk_i);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 2000);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 2000)
      check(32'h0, 32'h1);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] m, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(q & m, exp);
  endtask

  // Load a word, run one slot, then see it arrive both ways
  task automatic run_word(input pcs_word_type t, input pcs_word_type r);
    bus(1'b1, `PCS_TXDATA_OFS, {24'h0, t});
    pcs_dsp_model_inst.xfer(r, txw, ok);
    check({31'h0, ok}, 32'h1);
    check({24'h0, txw}, {24'h0, t});
    repeat (6) @(posedge sys_clk_i);
    rd_chk(`PCS_RXDATA_OFS, 32'h1FF, NEW | r);
    rd_chk(`PCS_RXDATA_OFS, 32'h1FF, {24'h0, r});
  endtask

  task automatic results();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Watchdog well beyond the expected run of under two thousand cycles
  initial
  begin
    #2000000;
    failures++;
    results();
  end

  initial
  begin
    failures = 0;
    checks_done = 0;
    rst_i = 1'b1;
    power_down_n_i = 1'b1;
    var_mode = 1'b0;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_byteenable = 4'hF;
    avs_writedata = 32'h0;
    repeat (5) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    repeat (5) @(posedge sys_clk_i);
    rd_chk(`PCS_TXDATA_OFS, 32'hFFFFFFFF, 32'h000000FF);
    rd_chk(`PCS_STATUS_OFS, ST_FIX | ST_ACT, ST_FIX | ST_ACT);
    rd_chk(4'hC, 32'hFFFFFFFF, 32'h0);
    $display("test reset done");
    for (k = 0; k < 4; k++)
      run_word(tx_tab[k], rx_tab[k]);
    bus(1'b1, `PCS_RXDATA_OFS, 32'h77);
    rd_chk(`PCS_RXDATA_OFS, 32'h1FF, 32'h0FF);
    $display("test fixed words done");
    repeat (300) @(posedge sys_clk_i);
    rd_chk(`PCS_STATUS_OFS, ST_RXS | ST_TXS, ST_RXS);
    repeat (200) @(posedge sys_clk_i);
    rd_chk(`PCS_STATUS_OFS, ST_RXS | ST_TXS, ST_RXS | ST_TXS);
    // Transmit-only slot must wake transmit alone
    pcs_dsp_model_inst.rx_skip = 1'b1;
    pcs_dsp_model_inst.xfer(8'h00, txw, ok);
    pcs_dsp_model_inst.rx_skip = 1'b0;
    check({31'h0, ok}, 32'h1);
    check({24'h0, txw}, {24'h0, tx_tab[3]});
    repeat (6) @(posedge sys_clk_i);
    rd_chk(`PCS_STATUS_OFS, ST_RXS | ST_TXS, ST_RXS);
    run_word(8'h55, 8'hAA);
    rd_chk(`PCS_STATUS_OFS, ST_RXS | ST_TXS, 32'h0);
    $display("test standby done");
    power_down_n_i <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
    rd_chk(`PCS_STATUS_OFS, ST_ACT, 32'h0);
    pcs_dsp_model_inst.xfer(8'h33, txw, ok);
    check({31'h0, ok}, 32'h0);
    repeat (6) @(posedge sys_clk_i);
    rd_chk(`PCS_RXDATA_OFS, NEW, 32'h0);
    power_down_n_i <= 1'b1;
    repeat (6) @(posedge sys_clk_i);
    run_word(8'hE7, 8'h18);
    $display("test power down done");
    var_mode <= 1'b1;
    repeat (20) @(posedge sys_clk_i);
    rd_chk(`PCS_STATUS_OFS, ST_FIX, 32'h0);
    run_word(8'h96, 8'h69);
    var_mode <= 1'b0;
    repeat (700) @(posedge sys_clk_i);
    rd_chk(`PCS_STATUS_OFS, ST_FIX, ST_FIX);
    run_word(8'h5A, 8'hA5);
    $display("test variable rate done");
    results();
  end
endmodule
